// ### rtl/cdac_pkg.sv
// Constants and types for the current output converter register bank
package cdac_pkg;

  //////////////////////////////////////////////////////////////////////////
  // Channel and field geometry
  localparam int NCH          = 4;
  localparam int COARSE_W     = 11;
  localparam int FINE_W       = 5;
  localparam int OUT_W        = 14;
  localparam int BW_W         = 4;
  localparam int COARSE_LSB   = 17;
  localparam int COARSE_MSB   = 27;
  localparam int FINE_LSB     = 12;
  localparam int FINE_MSB     = 16;
  localparam int HOLD_MSB     = 3;
  localparam int COARSE_SHIFT = 3;

  // Control register bit positions
  localparam int CTL_WEN = 7;
  localparam int CTL_SHT = 6;
  localparam int CTL_BWH = 5;
  localparam int CTL_BWL = 2;
  localparam int CTL_PUL = 1;
  localparam int CTL_PD  = 0;

  // Reset values
  localparam logic [7:0]  CTL_RST  = 8'h01;
  localparam logic [31:0] CODE_RST = 32'h0000_0000;

  //////////////////////////////////////////////////////////////////////////
  // Address map: window, block base, per channel stride
  localparam logic [19:0] WIN_PAGE    = 20'h40086;
  localparam logic [31:0] ADDR_CH0_CODE = 32'h4008_6800;
  localparam logic [31:0] ADDR_CH0_CTL  = 32'h4008_6804;
  localparam logic [31:0] ADDR_CH1_CODE = 32'h4008_6808;
  localparam logic [31:0] ADDR_CH1_CTL  = 32'h4008_680c;
  localparam logic [31:0] ADDR_CH2_CODE = 32'h4008_6810;
  localparam logic [31:0] ADDR_CH2_CTL  = 32'h4008_6814;
  localparam logic [31:0] ADDR_CH3_CODE = 32'h4008_6818;
  localparam logic [31:0] ADDR_CH3_CTL  = 32'h4008_681c;
  localparam logic [6:0]  BLK_SEL     = 7'h40;  // Address bits 11:5

  //////////////////////////////////////////////////////////////////////////
  // Access latency: CPU cycles at the CPU rate, expressed in system clocks
  localparam int CPU_ACC_CYC = 8;
  localparam int CPU_MHZ     = 80;
  localparam int SYS_MHZ     = 40;
  localparam int ACC_CYC     = (CPU_ACC_CYC * SYS_MHZ) / CPU_MHZ;
  localparam logic [3:0] ACC_LOAD = 4'(ACC_CYC - 1);

  // Link access sequencer
  typedef enum logic [0:0] {
    LNK_IDLE = 1'b0,
    LNK_BUSY = 1'b1
  } cdac_link_t;

endpackage

// ### rtl/cdac_regbank.sv
// Register bank and output code logic for four current output converters
// Function
// RULE1 - Coarse 11-bit code lives in code register bits 27..17.
// RULE2 - Fine 5-bit code lives in code register bits 16..12.
// RULE3 - Every code register holds four hold bits 3..0, bit n for channel n.
// RULE4 - Hold bit n set in all four registers freezes channel n output.
// RULE5 - Hold bit n clear anywhere lets a written code apply at once.
// RULE6 - Control bit 7 set enables code writes; clear clears the code.
// RULE7 - Control bit 0 set powers the channel down; clear powers up.
// RULE8 - Control registers reset to 0x01, all channels powered down.
// RULE9 - Code registers reset to zero, giving zero output current.
// RULE10 - Control bit 1 enables the pull-down current source.
// RULE11 - Control bit 6 enables overtemperature automatic shutdown.
// RULE12 - Control bits 5..2 drive the output filter bandwidth code.
// RULE13 - Zero in bits 27..12 gives a zero scale output.
// RULE14 - Registers sit in 0x40086xxx; each access takes 8 CPU cycles.
// RULE15 - Software powers the reference before clearing power down.
// RULE16 - Output equals coarse times 8 plus fine, fields overlapping.
// RULE17 - Software uses only bandwidth codes 0000 and 0101..1001.
// RULE18 - Code bits 31..28 and 11..4 read zero, writes ignored.
// RULE19 - Shutdown enabled plus overtemperature forces channel power down.
// RULE20 - Write enable low holds code at zero, discarding code writes.
`timescale 1ns/1ps

module cdac_regbank (
  // Clock and reset
  input  wire logic                   clk_sys,
  input  wire logic                   rst_n,
  // Die to die register link
  input  wire logic                   link_req,
  input  wire logic                   link_we,
  input  wire logic [31:0]            link_addr,
  input  wire logic [31:0]            link_wdata,
  output logic                        link_ready,
  output logic                        link_ack,
  output logic                        link_err,
  output logic      [31:0]            link_rdata,
  // Analog side status
  input  wire logic                   overtemp,
  // Analog side controls, one lane per channel
  output logic [cdac_pkg::NCH-1:0][cdac_pkg::OUT_W-1:0] out_code,
  output logic [cdac_pkg::NCH-1:0]                      power_down,
  output logic [cdac_pkg::NCH-1:0]                      pulldown_enable,
  output logic [cdac_pkg::NCH-1:0][cdac_pkg::BW_W-1:0]  filter_bandwidth_code
);

  ////////////////////////////////////////////////////////////////////////////
  // Storage
  logic [cdac_pkg::COARSE_W-1:0] coarse_code_q [cdac_pkg::NCH];
  logic [cdac_pkg::FINE_W-1:0]   fine_code_q   [cdac_pkg::NCH];
  logic [cdac_pkg::NCH-1:0]      hold_q        [cdac_pkg::NCH];
  logic [7:0]                    ctl_q         [cdac_pkg::NCH];
  logic [cdac_pkg::OUT_W-1:0]    applied_q     [cdac_pkg::NCH];

  // Link sequencer
  cdac_pkg::cdac_link_t          state_q;
  logic [3:0]                    cnt_q;
  logic [31:0]                   rdata_q;
  logic                          err_q;
  logic                          done;

  // Decode
  logic                          hit;
  logic                          sel_ctl;
  logic [1:0]                    sel_ch;
  logic                          take;
  logic                          wr_take;
  logic [31:0]                   rd_word;
  logic [cdac_pkg::NCH-1:0]      hold_all;

  // Next register contents, one entry per channel
  logic [cdac_pkg::COARSE_W-1:0] coarse_d      [cdac_pkg::NCH];
  logic [cdac_pkg::FINE_W-1:0]   fine_d        [cdac_pkg::NCH];
  logic [cdac_pkg::NCH-1:0]      hold_d        [cdac_pkg::NCH];
  logic [7:0]                    ctl_d         [cdac_pkg::NCH];
  logic [cdac_pkg::OUT_W-1:0]    applied_d     [cdac_pkg::NCH];

  // Width used for the combined output code
  localparam int OW = cdac_pkg::OUT_W;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode
  // Only the eight word addresses of the bank answer; anything else in the
  // window or outside it completes with an error and reads as zero.
  // Full 32-bit compares cost a little area but reject every alias.
  always_comb begin
    hit     = 1'b1;
    sel_ctl = 1'b0;
    sel_ch  = 2'h0;
    if (link_addr == cdac_pkg::ADDR_CH0_CODE) begin  // RULE14
      sel_ch  = 2'h0;
    end else if (link_addr == cdac_pkg::ADDR_CH0_CTL) begin
      sel_ch  = 2'h0;
      sel_ctl = 1'b1;
    end else if (link_addr == cdac_pkg::ADDR_CH1_CODE) begin
      sel_ch  = 2'h1;
    end else if (link_addr == cdac_pkg::ADDR_CH1_CTL) begin
      sel_ch  = 2'h1;
      sel_ctl = 1'b1;
    end else if (link_addr == cdac_pkg::ADDR_CH2_CODE) begin
      sel_ch  = 2'h2;
    end else if (link_addr == cdac_pkg::ADDR_CH2_CTL) begin
      sel_ch  = 2'h2;
      sel_ctl = 1'b1;
    end else if (link_addr == cdac_pkg::ADDR_CH3_CODE) begin
      sel_ch  = 2'h3;
    end else if (link_addr == cdac_pkg::ADDR_CH3_CTL) begin
      sel_ch  = 2'h3;
      sel_ctl = 1'b1;
    end else begin
      hit = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Handshake
  // One request at a time: ready is low for the whole access, but a
  // request that stays up past its acknowledge edge is taken again.
  assign take       = (state_q == cdac_pkg::LNK_IDLE) && link_req;
  assign done       = (state_q == cdac_pkg::LNK_BUSY) && (cnt_q == 4'h0);
  assign wr_take    = done && link_we && hit;
  assign link_ready = (state_q == cdac_pkg::LNK_IDLE);
  assign link_ack   = done;
  assign link_err   = done && err_q;
  assign link_rdata = rdata_q;

  // Access sequencer
  // A fixed count stands in for the die to die latency. The request is
  // taken on one edge and acknowledged on the edge that follows the
  // count; writes land on that acknowledge edge using the address and data
  // then on the link, so a master that drops the request early still writes.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= cdac_pkg::LNK_IDLE;
      cnt_q   <= 4'h0;
    end else begin
      case (state_q)
        cdac_pkg::LNK_IDLE: begin
          if (take) begin
            state_q <= cdac_pkg::LNK_BUSY;
            cnt_q   <= cdac_pkg::ACC_LOAD;  // RULE14
          end
        end
        cdac_pkg::LNK_BUSY: begin
          if (cnt_q == 4'h0) begin
            state_q <= cdac_pkg::LNK_IDLE;
          end else begin
            cnt_q <= cnt_q - 4'h1;
          end
        end
        default: begin
          state_q <= cdac_pkg::LNK_IDLE;
        end
      endcase
    end
  end

  // Read data and error are captured when the request is taken, so
  // they stand unchanged until the acknowledge is sampled
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 32'h0000_0000;
      err_q   <= 1'b0;
    end else if (take) begin
      rdata_q <= rd_word;
      err_q   <= !hit;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path
  // Reserved code bits are never stored, so they read back as zero.
  // Control registers are eight bits wide; the upper bits read zero.
  always_comb begin
    rd_word = 32'h0000_0000;
    if (hit && sel_ctl) begin
      rd_word[7:0] = ctl_q[sel_ch];
    end else if (hit) begin
      rd_word[cdac_pkg::COARSE_MSB:cdac_pkg::COARSE_LSB] =
        coarse_code_q[sel_ch];  // RULE1
      rd_word[cdac_pkg::FINE_MSB:cdac_pkg::FINE_LSB] =
        fine_code_q[sel_ch];  // RULE2
      rd_word[cdac_pkg::HOLD_MSB:0] = hold_q[sel_ch];  // RULE3 RULE18
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next register contents
  // Clearing wins over a code write in the same access: while the write
  // enable bit is low the coarse and fine fields stay at zero. The hold
  // bits are shared between channels and stay writable either way.
  always_comb begin
    for (int ch = 0; ch < cdac_pkg::NCH; ch++) begin
      coarse_d[ch] = coarse_code_q[ch];
      fine_d[ch]   = fine_code_q[ch];
      hold_d[ch]   = hold_q[ch];
      ctl_d[ch]    = ctl_q[ch];
      if (wr_take && (sel_ch == 2'(ch))) begin
        if (sel_ctl) begin
          ctl_d[ch] = link_wdata[7:0];  // RULE7 RULE10 RULE11 RULE12
        end else begin
          coarse_d[ch] =
            link_wdata[cdac_pkg::COARSE_MSB:cdac_pkg::COARSE_LSB];  // RULE1
          fine_d[ch] =
            link_wdata[cdac_pkg::FINE_MSB:cdac_pkg::FINE_LSB];  // RULE2
          hold_d[ch] = link_wdata[cdac_pkg::HOLD_MSB:0];  // RULE3 RULE18
        end
      end
      if (!ctl_d[ch][cdac_pkg::CTL_WEN]) begin  // RULE6 RULE20
        coarse_d[ch] = '0;
        fine_d[ch]   = '0;
      end
    end
  end

  // A channel is held only when its hold bit is set in all four registers;
  // the next hold values are used so a release applies on its own write
  always_comb begin
    hold_all = '1;
    for (int ch = 0; ch < cdac_pkg::NCH; ch++) begin
      hold_all = hold_all & hold_d[ch];  // RULE4
    end
  end

  // Combined code: fine's top two bits overlap coarse's bottom two, so
  // the sum can pass the top code; it wraps within the 14-bit output
  always_comb begin
    for (int ch = 0; ch < cdac_pkg::NCH; ch++) begin
      applied_d[ch] = (OW'(coarse_d[ch]) << cdac_pkg::COARSE_SHIFT)
                    + OW'(fine_d[ch]);  // RULE16 RULE13
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register storage
  // Everything returns to its documented reset value on the async reset;
  // the reset branch reads constants only.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      for (int ch = 0; ch < cdac_pkg::NCH; ch++) begin
        coarse_code_q[ch] <=  // RULE9
          cdac_pkg::CODE_RST[cdac_pkg::COARSE_MSB:cdac_pkg::COARSE_LSB];
        fine_code_q[ch]   <=
          cdac_pkg::CODE_RST[cdac_pkg::FINE_MSB:cdac_pkg::FINE_LSB];
        hold_q[ch]        <= cdac_pkg::CODE_RST[cdac_pkg::HOLD_MSB:0];
        ctl_q[ch]         <= cdac_pkg::CTL_RST;  // RULE8
      end
    end else begin
      for (int ch = 0; ch < cdac_pkg::NCH; ch++) begin
        coarse_code_q[ch] <= coarse_d[ch];
        fine_code_q[ch]   <= fine_d[ch];
        hold_q[ch]        <= hold_d[ch];
        ctl_q[ch]         <= ctl_d[ch];
      end
    end
  end

  // Applied code: a held channel keeps its last code; the stored code
  // moves on and is applied in the same edge that clears the hold
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      for (int ch = 0; ch < cdac_pkg::NCH; ch++) begin
        applied_q[ch] <= '0;  // RULE9
      end
    end else begin
      for (int ch = 0; ch < cdac_pkg::NCH; ch++) begin
        if (!hold_all[ch]) begin  // RULE4 RULE5
          applied_q[ch] <= applied_d[ch];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Analog side controls
  // Power down is a flop, so the overtemperature force reaches the pin one
  // clock after the input; the input is taken as already synchronous.
  // The force does not touch the stored power down bit, so the channel
  // comes back by itself once the condition clears.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      power_down            <=
        {cdac_pkg::NCH{cdac_pkg::CTL_RST[cdac_pkg::CTL_PD]}};  // RULE8
      pulldown_enable       <= '0;
      filter_bandwidth_code <= '0;
    end else begin
      for (int ch = 0; ch < cdac_pkg::NCH; ch++) begin
        power_down[ch]      <= ctl_d[ch][cdac_pkg::CTL_PD]  // RULE7
                             | (ctl_d[ch][cdac_pkg::CTL_SHT]
                             & overtemp);  // RULE11 RULE19
        pulldown_enable[ch] <= ctl_d[ch][cdac_pkg::CTL_PUL];  // RULE10
        filter_bandwidth_code[ch] <=
          ctl_d[ch][cdac_pkg::CTL_BWH:cdac_pkg::CTL_BWL];  // RULE12
      end
    end
  end

  // Output codes come straight from the applied code flops,
  // with no logic between flop and pin
  always_comb begin
    for (int ch = 0; ch < cdac_pkg::NCH; ch++) begin
      out_code[ch] = applied_q[ch];
    end
  end

endmodule

// ### tb/cdac_regbank_asserts.sv
// Port checks for the converter register bank
`timescale 1ns/1ps
module cdac_regbank_asserts (input wire logic clk_sys, rst_n, link_req,
  input wire logic link_we, link_ack, link_ready, link_err,
  input wire logic [3:0] power_down,
  input wire logic [3:0][13:0] out_code,
  input wire logic [3:0][3:0] filter_bandwidth_code);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  rst_val_a: assert property ($rose(rst_n) |-> &power_down
    && out_code == '0) else $error("reset values wrong");
  acc_lat_a: assert property ($rose(link_req) |-> ##[3:8] link_ack)
    else $error("access latency wrong");
  bw_src_a: assert property ($changed(filter_bandwidth_code)
    |-> $past(link_req && link_we)) else $error("bw moved without write");
  acc_exact_a: assert property (link_ready && link_req |-> ##4 link_ack)
    else $error("access took the wrong number of cycles");
  ack_pulse_a: assert property (link_ack |=> !link_ack)
    else $error("acknowledge longer than one cycle");
  err_ack_a: assert property (link_err |-> link_ack)
    else $error("error without acknowledge");
  out_write_a: assert property ($changed(out_code)
    |-> $past(link_ack && link_we)) else $error("code moved without write");
endmodule
bind cdac_regbank cdac_regbank_asserts chk (.*);

// ### tb/cdac_cpu_model.sv
// CPU model issuing die to die register accesses
`timescale 1ns/1ps
module cdac_cpu_model (input wire logic clk_sys, link_ack, link_err,
  input wire logic [31:0] link_rdata, output logic link_req = 1'b0,
  link_we = 1'b0, output logic [31:0] link_addr = '0, link_wdata = '0);
  task automatic xfer(logic w, logic [31:0] a, d, output logic [31:0] q,
    output logic e);
    @(negedge clk_sys);
    {link_req, link_we, link_addr, link_wdata} = {1'b1, w, a, d};
    do @(posedge clk_sys); while (link_ack !== 1'b1);
    q = link_rdata;
    e = link_err;
    @(negedge clk_sys) {link_req, link_addr, link_wdata} = {1'b0, ~a, ~d};
  endtask
endmodule

// ### tb/test_cdac_regbank.sv
// Self-checking bench for the converter register bank
`timescale 1ns/1ps
module test_cdac_regbank;
  logic clk_sys = 1'b0, rst_n = 1'b0, overtemp = 1'b0;
  logic link_req, link_we, link_ack, link_ready, link_err;
  logic [31:0] link_addr, link_wdata, link_rdata, q;
  logic e;
  logic [3:0][13:0] out_code;
  logic [3:0][3:0] filter_bandwidth_code;
  logic [3:0] power_down, pulldown_enable;
  int bad_count = 0, compares = 0, cyc = 0;
  always #12.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (++cyc == 2000) conclude(1);
  cdac_regbank dut (.*);
  cdac_cpu_model cpu (.*);
  task automatic cmp(logic [31:0] got, exp);
    compares++;
    if (got !== exp) bad_count++;
    if (got !== exp) $display("CHECK FAILED %0t %h %h", $time, got, exp);
  endtask
  task automatic conclude(int h);
    if (bad_count + h == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic t_power_up;
    cpu.xfer(1, 32'h4008680c, 32'h9a, q, e);
    cmp({power_down, pulldown_enable}, 32'hd2);
    cmp(filter_bandwidth_code[1], 32'h6);
    cmp(e, 32'h0);
  endtask
  task automatic t_quarter;
    cpu.xfer(1, 32'h40086808, 32'hf3fe0ff0, q, e);
    cmp(out_code[1], 32'hff8);
    cpu.xfer(0, 32'h40086808, 0, q, e);
    cmp(q, 32'h03fe0000);
    cpu.xfer(1, 32'h40086808, 32'h03fcf000, q, e);
    cmp(out_code[1], 32'hfff);
  endtask
  task automatic t_hold;
    cpu.xfer(1, 32'h40086814, 32'h81, q, e);
    cpu.xfer(1, 32'h40086800, 32'h4, q, e);
    cpu.xfer(1, 32'h40086808, 32'h03fe0004, q, e);
    cpu.xfer(1, 32'h40086818, 32'h4, q, e);
    cpu.xfer(1, 32'h40086810, 32'h00200004, q, e);
    cmp(out_code[2], 32'h0);
    cmp(out_code[1], 32'hff8);
    cpu.xfer(0, 32'h40086810, 0, q, e);
    cmp(q, 32'h00200004);
    cpu.xfer(1, 32'h40086818, 32'h0, q, e);
    cmp(out_code[2], 32'h80);
  endtask
  task automatic t_clear;
    cpu.xfer(1, 32'h4008680c, 32'h1a, q, e);
    cmp(out_code[1], 32'h0);
    cpu.xfer(1, 32'h40086808, 32'h03fe0000, q, e);
    cpu.xfer(0, 32'h40086808, 0, q, e);
    cmp(q, 32'h0);
    cpu.xfer(0, 32'h4008680c, 0, q, e);
    cmp(q, 32'h1a);
  endtask
  task automatic t_shutdown;
    cpu.xfer(1, 32'h4008681c, 32'h40, q, e);
    cmp(power_down, 32'h5);
    overtemp = 1'b1;
    repeat (2) @(negedge clk_sys);
    cmp(power_down, 32'hd);
    overtemp = 1'b0;
    repeat (2) @(negedge clk_sys);
    cmp(power_down, 32'h5);
  endtask
  task automatic t_error;
    cpu.xfer(0, 32'h40086820, 0, q, e);
    cmp(e, 32'h1);
    cmp(q, 32'h0);
    cmp(link_ready, 32'h1);
  endtask
  initial begin
    #400 rst_n = 1'b1;
    t_power_up();
    t_quarter();
    t_hold();
    t_clear();
    t_shutdown();
    t_error();
    conclude(0);
  end
endmodule
